/* include/scc_pkg.sv */
// scc_pkg: register map, field positions and command codes of the serial channel control block
// assumes: byte-wide registers on even byte offsets, one block instance holds four channels
package scc_pkg;
	// ==========================================================
	// geometry
	localparam int unsigned SCC_NCHAN      = 4;
	localparam int unsigned SCC_AW         = 8;
	localparam int unsigned SCC_DW         = 8;
	// ==========================================================
	// byte offsets inside one channel window
	localparam logic [5:0]  SCC_OFF_CAL    = 6'h00;
	localparam logic [5:0]  SCC_OFF_CAH    = 6'h02;
	localparam logic [5:0]  SCC_OFF_CML    = 6'h04;
	localparam logic [5:0]  SCC_OFF_CMH    = 6'h06;
	localparam logic [5:0]  SCC_OFF_CSL    = 6'h08;
	localparam logic [5:0]  SCC_OFF_CSH    = 6'h0a;
	localparam logic [5:0]  SCC_OFF_CCL    = 6'h0c;
	localparam logic [5:0]  SCC_OFF_CCH    = 6'h0e;
	// channel select sits above the per-channel window
	localparam int unsigned SCC_CH_LSB     = 6;
	// ==========================================================
	// internal five-bit register addresses
	localparam logic [4:0]  SCC_IA_MODE    = 5'h01;
	localparam logic [4:0]  SCC_IA_CSTAT   = 5'h02;
	localparam logic [4:0]  SCC_IA_CCTRL   = 5'h03;
	// ==========================================================
	// field positions
	localparam int unsigned SCC_CAL_ADDR_LSB = 1;
	localparam int unsigned SCC_CAH_RST      = 2;
	localparam int unsigned SCC_CAH_CMD_LSB  = 3;
	localparam int unsigned SCC_CSH_RCC_CLR  = 5;
	localparam int unsigned SCC_CCL_WAIT     = 5;
	localparam int unsigned SCC_CCH_WAIT     = 5;
	// writable masks of mixed registers, and the register reset byte
	localparam logic [7:0]  SCC_CSL_WMASK  = 8'h3c;
	localparam logic [7:0]  SCC_CSH_WMASK  = 8'h1f;
	localparam logic [7:0]  SCC_CCL_WMASK  = 8'he0;
	localparam logic [7:0]  SCC_RST_BYTE   = 8'h00;
	// ==========================================================
	typedef enum logic [1:0] {
		SCC_OP_NORMAL,
		SCC_OP_ECHO,
		SCC_OP_EXT_LOOP,
		SCC_OP_INT_LOOP
	} scc_opmode_e;

	typedef enum logic [4:0] {
		SCC_CMD_NULL       = 5'h00,
		SCC_CMD_RST_IUS    = 5'h02,
		SCC_CMD_DMA_LOAD   = 5'h04,
		SCC_CMD_DMA_RX     = 5'h05,
		SCC_CMD_DMA_TX     = 5'h06,
		SCC_CMD_DMA_BOTH   = 5'h07,
		SCC_CMD_PURGE_RX   = 5'h09,
		SCC_CMD_PURGE_TX   = 5'h0a,
		SCC_CMD_PURGE_BOTH = 5'h0b,
		SCC_CMD_CNT_RX     = 5'h0d,
		SCC_CMD_CNT_TX     = 5'h0e,
		SCC_CMD_CNT_BOTH   = 5'h0f,
		SCC_CMD_TC0        = 5'h11,
		SCC_CMD_TC1        = 5'h12,
		SCC_CMD_TC_BOTH    = 5'h13,
		SCC_CMD_LSB_FIRST  = 5'h14,
		SCC_CMD_MSB_FIRST  = 5'h15,
		SCC_CMD_STRAIGHT   = 5'h16,
		SCC_CMD_SWAPPED    = 5'h17,
		SCC_CMD_RX_PURGE   = 5'h19
	} scc_cmd_e;

	// pulse vector bit positions
	localparam int unsigned SCC_P_IUS      = 0;
	localparam int unsigned SCC_P_DMA_LOAD = 1;
	localparam int unsigned SCC_P_DMA_RX   = 2;
	localparam int unsigned SCC_P_DMA_TX   = 3;
	localparam int unsigned SCC_P_PRG_RX   = 4;
	localparam int unsigned SCC_P_PRG_TX   = 5;
	localparam int unsigned SCC_P_CNT_RX   = 6;
	localparam int unsigned SCC_P_CNT_TX   = 7;
	localparam int unsigned SCC_P_TC0      = 8;
	localparam int unsigned SCC_P_TC1      = 9;
	localparam int unsigned SCC_P_RXPURGE  = 10;
	localparam int unsigned SCC_NPULSE     = 11;

	localparam logic [3:0]  SCC_RXMODE_LAST = 4'h9;
	localparam logic [3:0]  SCC_TXMODE_RSV1 = 4'h1;
	localparam logic [3:0]  SCC_TXMODE_SMS  = 4'hc;
	localparam logic [3:0]  SCC_TXMODE_HLP  = 4'he;
	localparam logic [1:0]  SCC_SB_RSV      = 2'h3;
endpackage

/* hw/scc_cmd_dec.sv */
// scc_cmd_dec: decodes one five-bit channel command into one-cycle action pulses
// assumes: strobe is a single cycle on the block clock
`timescale 1ns/10ps
`default_nettype none
module scc_cmd_dec
	import scc_pkg::*;
(
	input  wire logic                  stb_in,    // command write strobe
	input  wire logic [4:0]            code_in,   // command code
	output logic [SCC_NPULSE-1:0]      pulse_out, // action pulses
	output logic                       lsb_sel_out, // set lsb-first
	output logic                       msb_sel_out, // set msb-first
	output logic                       str_sel_out, // set straight order
	output logic                       swp_sel_out  // set swapped order
);
	always_comb begin
		pulse_out   = '0;
		lsb_sel_out = 1'b0;
		msb_sel_out = 1'b0;
		str_sel_out = 1'b0;
		swp_sel_out = 1'b0;
		if (stb_in) begin
			unique case (code_in)
				SCC_CMD_RST_IUS:    pulse_out[SCC_P_IUS] = 1'b1;       // [RULE8]
				SCC_CMD_DMA_LOAD:   pulse_out[SCC_P_DMA_LOAD] = 1'b1;  // [RULE6]
				SCC_CMD_DMA_RX:     pulse_out[SCC_P_DMA_RX] = 1'b1;    // [RULE6]
				SCC_CMD_DMA_TX:     pulse_out[SCC_P_DMA_TX] = 1'b1;    // [RULE6]
				SCC_CMD_DMA_BOTH: begin                                // [RULE6]
					pulse_out[SCC_P_DMA_RX] = 1'b1;
					pulse_out[SCC_P_DMA_TX] = 1'b1;
				end
				SCC_CMD_PURGE_RX:   pulse_out[SCC_P_PRG_RX] = 1'b1;    // [RULE7]
				SCC_CMD_PURGE_TX:   pulse_out[SCC_P_PRG_TX] = 1'b1;    // [RULE7]
				SCC_CMD_PURGE_BOTH: begin                              // [RULE7]
					pulse_out[SCC_P_PRG_RX] = 1'b1;
					pulse_out[SCC_P_PRG_TX] = 1'b1;
				end
				SCC_CMD_CNT_RX:     pulse_out[SCC_P_CNT_RX] = 1'b1;    // [RULE7]
				SCC_CMD_CNT_TX:     pulse_out[SCC_P_CNT_TX] = 1'b1;    // [RULE7]
				SCC_CMD_CNT_BOTH: begin                                // [RULE7]
					pulse_out[SCC_P_CNT_RX] = 1'b1;
					pulse_out[SCC_P_CNT_TX] = 1'b1;
				end
				SCC_CMD_TC0:        pulse_out[SCC_P_TC0] = 1'b1;       // [RULE8]
				SCC_CMD_TC1:        pulse_out[SCC_P_TC1] = 1'b1;       // [RULE8]
				SCC_CMD_TC_BOTH: begin                                 // [RULE8]
					pulse_out[SCC_P_TC0] = 1'b1;
					pulse_out[SCC_P_TC1] = 1'b1;
				end
				SCC_CMD_RX_PURGE:   pulse_out[SCC_P_RXPURGE] = 1'b1;   // [RULE8]
				SCC_CMD_LSB_FIRST:  lsb_sel_out = 1'b1;                // [RULE9]
				SCC_CMD_MSB_FIRST:  msb_sel_out = 1'b1;                // [RULE9]
				SCC_CMD_STRAIGHT:   str_sel_out = 1'b1;                // [RULE10]
				SCC_CMD_SWAPPED:    swp_sel_out = 1'b1;                // [RULE10]
				// null and reserved codes do nothing
				default: pulse_out = '0;                               // [RULE23]
			endcase
		end
	end
endmodule
`default_nettype wire

/* hw/scc_ctrl.sv */
// scc_ctrl: four-channel serial control front end (command/address, mode, status, control)
// assumes: host port with one-cycle strobes and read data in the following cycle;
// status inputs come from channel logic on the same clock
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// RULE1: four channels, identical register layout
// RULE2: internal addresses mode 1, status 2, control 3
// RULE3: software sets lower byte select
// RULE4: software sets byte access
// RULE5: two-bit loop-back/echo operating mode
// RULE6: commands trigger load, rx, tx DMA
// RULE7: commands purge FIFOs and load counters
// RULE8: time constant loads, rx purge, INTERRUPT_IN_SERVICE reset
// RULE9: bit order select, lsb first at reset
// RULE10: memory byte order, straight at reset
// RULE11: receiver mode field and reserved codes
// RULE12: transmitter mode field, its own codes
// RULE13: last character length binary, 0..7
// RULE14: count FIFO clear, valid, overflow
// RULE15: PLL sync and clocks-missed status bits
// RULE16: receive status block select
// RULE17: receiver waits for rx DMA trigger
// RULE18: tx status block and tx wait
// RULE19: preamble length and pattern fields
// RULE20: flag preamble select
// RULE21: async stop bit shave field
// RULE22: loop sending and on-loop status
// RULE23: reserved commands change nothing
// RULE24: channel reset restores defaults
module scc_ctrl
	import scc_pkg::*;
#(
	parameter int unsigned NCH = SCC_NCHAN
)(
	input  wire logic                  mclk_in,          // 250 MHz clock
	input  wire logic                  nrst_in,          // async reset, low
	input  wire logic [SCC_AW-1:0]     addr_in,          // byte address
	input  wire logic [SCC_DW-1:0]     wdata_in,         // write data
	input  wire logic                  wr_in,            // write strobe
	input  wire logic                  rd_in,            // read strobe
	output logic      [SCC_DW-1:0]     rdata_out,        // read data, next cycle
	input  wire logic [NCH-1:0]        tx_ack_in,        // tx acknowledge level
	input  wire logic [NCH-1:0]        rx_ack_in,        // rx acknowledge level
	input  wire logic [NCH-1:0]        loop_sending_in,  // tx sending onto loop
	input  wire logic [NCH-1:0]        on_loop_in,       // channel on the loop
	input  wire logic [NCH-1:0]        pll_sync_in,      // pll in sync
	input  wire logic [NCH-1:0]        clk_missed_in,    // clock missed event
	input  wire logic [NCH-1:0]        rcc_push_in,      // count fifo entry pushed
	input  wire logic [NCH-1:0]        rcc_pop_in,       // count fifo entry taken
	output logic [NCH-1:0][1:0]        op_mode_out,      // operating mode
	output logic [NCH-1:0][3:0]        rx_mode_out,      // receiver mode
	output logic [NCH-1:0][3:0]        tx_mode_out,      // transmitter mode
	output logic [NCH-1:0]             mode_rsv_out,     // reserved mode or status block code written
	output logic [NCH-1:0][2:0]        last_len_out,     // last char bit count
	output logic [NCH-1:0][1:0]        rx_sblk_out,      // rx status block words
	output logic [NCH-1:0][1:0]        tx_sblk_out,      // tx status block words
	output logic [NCH-1:0][6:0]        pre_len_out,      // preamble bits, 8..64
	output logic [NCH-1:0][1:0]        pre_pat_out,      // preamble pattern
	output logic [NCH-1:0]             pre_flag_out,     // flag preamble
	output logic [NCH-1:0][3:0]        shave_out,        // async stop shave
	output logic [NCH-1:0]             msb_first_out,    // serial msb first
	output logic [NCH-1:0]             swapped_out,      // memory bytes swapped
	output logic [NCH-1:0]             rx_go_out,        // receiver may move data
	output logic [NCH-1:0]             tx_go_out,        // transmitter may move data
	output logic [NCH-1:0][SCC_NPULSE-1:0] pulse_out,    // one-cycle command actions
	output logic [NCH-1:0]             chan_rst_out      // channel reset pulse
);
	// ==========================================================
	// address decode
	function automatic logic hit(input logic [SCC_AW-1:0] a, input logic [5:0] off);
		hit = (a[SCC_CH_LSB-1:0] == off);
	endfunction

	logic [1:0] ch;
	assign ch = addr_in[SCC_CH_LSB +: 2];

	logic [NCH-1:0] cah_wr;
	logic [NCH-1:0][4:0] iaddr_q;
	logic [NCH-1:0][1:0] op_q;
	logic [NCH-1:0][7:0] cml_q, cmh_q, csl_q, csh_q, ccl_q, cch_q;
	logic [NCH-1:0] rcc_valid_q, rcc_ovf_q, miss_q, go_rx_q, go_tx_q;
	logic [NCH-1:0] msb_q, swp_q;
	logic [NCH-1:0] lsb_s, msb_s, str_s, swp_s;
	logic [NCH-1:0][3:0] rcc_cnt_q;
	localparam logic [3:0] RCC_DEPTH = 4'h8;

	// ==========================================================
	// per-channel logic, one copy for each channel
	for (genvar c = 0; c < NCH; c++) begin : g_ch                // [RULE1]
		logic sel, wr;
		logic rst;
		assign sel = (ch == 2'(c));
		assign wr  = wr_in && sel;
		assign cah_wr[c] = wr && hit(addr_in, SCC_OFF_CAH);
		assign rst = cah_wr[c] && wdata_in[SCC_CAH_RST];        // [RULE24]
		assign chan_rst_out[c] = rst;

		scc_cmd_dec u_dec (
			.stb_in      (cah_wr[c] && !rst),
			.code_in     (wdata_in[SCC_CAH_CMD_LSB +: 5]),
			.pulse_out   (pulse_out[c]),
			.lsb_sel_out (lsb_s[c]),
			.msb_sel_out (msb_s[c]),
			.str_sel_out (str_s[c]),
			.swp_sel_out (swp_s[c])
		);

		// command/address and operating mode
		always_ff @(posedge mclk_in or negedge nrst_in) begin
			if (!nrst_in) begin
				iaddr_q[c] <= '0;
				op_q[c]    <= SCC_OP_NORMAL;
			end else if (rst) begin
				iaddr_q[c] <= '0;
				op_q[c]    <= SCC_OP_NORMAL;
			end else begin
				if (wr && hit(addr_in, SCC_OFF_CAL))
					iaddr_q[c] <= wdata_in[SCC_CAL_ADDR_LSB +: 5]; // [RULE2]
				if (cah_wr[c])
					op_q[c] <= wdata_in[1:0];                      // [RULE5]
			end
		end

		// bit and byte order selects
		always_ff @(posedge mclk_in or negedge nrst_in) begin
			if (!nrst_in) begin
				msb_q[c] <= 1'b0;
				swp_q[c] <= 1'b0;
			end else if (rst) begin
				msb_q[c] <= 1'b0;                                  // [RULE9]
				swp_q[c] <= 1'b0;                                  // [RULE10]
			end else begin
				if (lsb_s[c]) msb_q[c] <= 1'b0;                    // [RULE9]
				if (msb_s[c]) msb_q[c] <= 1'b1;                    // [RULE9]
				if (str_s[c]) swp_q[c] <= 1'b0;                    // [RULE10]
				if (swp_s[c]) swp_q[c] <= 1'b1;                    // [RULE10]
			end
		end

		// mode, status and control registers, written only at their direct offsets; low bytes also read via internal address
		logic w_cml, w_cmh, w_csl, w_csh, w_ccl, w_cch;
		assign w_cml = wr && hit(addr_in, SCC_OFF_CML);
		assign w_cmh = wr && hit(addr_in, SCC_OFF_CMH);
		assign w_csl = wr && hit(addr_in, SCC_OFF_CSL);
		assign w_csh = wr && hit(addr_in, SCC_OFF_CSH);
		assign w_ccl = wr && hit(addr_in, SCC_OFF_CCL);
		assign w_cch = wr && hit(addr_in, SCC_OFF_CCH);
		always_ff @(posedge mclk_in or negedge nrst_in) begin
			if (!nrst_in) begin
				cml_q[c] <= SCC_RST_BYTE;
				cmh_q[c] <= SCC_RST_BYTE;
				csl_q[c] <= SCC_RST_BYTE;
				csh_q[c] <= SCC_RST_BYTE;
				ccl_q[c] <= SCC_RST_BYTE;
				cch_q[c] <= SCC_RST_BYTE;
			end else if (rst) begin
				cml_q[c] <= SCC_RST_BYTE;                          // [RULE24]
				cmh_q[c] <= SCC_RST_BYTE;
				csl_q[c] <= SCC_RST_BYTE;
				csh_q[c] <= SCC_RST_BYTE;
				ccl_q[c] <= SCC_RST_BYTE;
				cch_q[c] <= SCC_RST_BYTE;
			end else begin
				if (w_cml) cml_q[c] <= wdata_in;                   // [RULE11]
				if (w_cmh) cmh_q[c] <= wdata_in;                   // [RULE12]
				if (w_csl) csl_q[c] <= wdata_in & SCC_CSL_WMASK;   // [RULE13]
				if (w_csh) csh_q[c] <= wdata_in & SCC_CSH_WMASK;
				if (w_ccl) ccl_q[c] <= wdata_in & SCC_CCL_WMASK;   // [RULE16]
				if (w_cch) cch_q[c] <= wdata_in;                   // [RULE18]
			end
		end

		// received character count fifo status; a push in the clear cycle survives
		always_ff @(posedge mclk_in or negedge nrst_in) begin
			if (!nrst_in) begin
				rcc_cnt_q[c]   <= '0;
				rcc_ovf_q[c]   <= 1'b0;
			end else begin
				if (rst || (w_csh && wdata_in[SCC_CSH_RCC_CLR])) begin // [RULE14]
					rcc_cnt_q[c] <= rcc_push_in[c] ? 4'h1 : 4'h0;
					rcc_ovf_q[c] <= 1'b0;
				end else if (rcc_push_in[c] && !rcc_pop_in[c]) begin
					if (rcc_cnt_q[c] == RCC_DEPTH)
						rcc_ovf_q[c] <= 1'b1;                      // [RULE14]
					else
						rcc_cnt_q[c] <= rcc_cnt_q[c] + 4'h1;
				end else if (rcc_pop_in[c] && !rcc_push_in[c] && rcc_cnt_q[c] != 4'h0) begin
					rcc_cnt_q[c] <= rcc_cnt_q[c] - 4'h1;
				end
			end
		end
		assign rcc_valid_q[c] = (rcc_cnt_q[c] != 4'h0);

		// latched clocks-missed; event beats a same-cycle software clear
		always_ff @(posedge mclk_in or negedge nrst_in) begin
			if (!nrst_in)
				miss_q[c] <= 1'b0;
			else if (clk_missed_in[c])
				miss_q[c] <= 1'b1;                                 // [RULE15]
			else if (rst || (w_csh && wdata_in[3:2] != 2'b00))
				miss_q[c] <= 1'b0;
		end

		// dma-trigger gating of receiver and transmitter
		always_ff @(posedge mclk_in or negedge nrst_in) begin
			if (!nrst_in) begin
				go_rx_q[c] <= 1'b0;
				go_tx_q[c] <= 1'b0;
			end else if (rst) begin
				go_rx_q[c] <= 1'b0;
				go_tx_q[c] <= 1'b0;
			end else begin
				if (pulse_out[c][SCC_P_DMA_RX] || pulse_out[c][SCC_P_PRG_RX])
					go_rx_q[c] <= pulse_out[c][SCC_P_DMA_RX];      // [RULE17]
				if (pulse_out[c][SCC_P_DMA_TX] || pulse_out[c][SCC_P_PRG_TX])
					go_tx_q[c] <= pulse_out[c][SCC_P_DMA_TX];      // [RULE18]
			end
		end

		// field outputs
		assign op_mode_out[c]  = op_q[c];                          // [RULE5]
		assign rx_mode_out[c]  = cml_q[c][3:0];                    // [RULE11]
		assign tx_mode_out[c]  = cmh_q[c][3:0];                    // [RULE12]
		assign mode_rsv_out[c] = (cml_q[c][3:0] > SCC_RXMODE_LAST)  // [RULE11]
			|| (cmh_q[c][3:0] == SCC_TXMODE_RSV1)                   // [RULE12]
			|| ((cmh_q[c][3:0] > SCC_RXMODE_LAST)
				&& (cmh_q[c][3:0] != SCC_TXMODE_SMS)
				&& (cmh_q[c][3:0] != SCC_TXMODE_HLP))
			|| (ccl_q[c][7:6] == SCC_SB_RSV) || (cch_q[c][7:6] == SCC_SB_RSV);
		assign last_len_out[c] = csl_q[c][4:2];                    // [RULE13]
		assign rx_sblk_out[c]  = ccl_q[c][7:6];                    // [RULE16]
		assign tx_sblk_out[c]  = cch_q[c][7:6];                    // [RULE18]
		assign pre_len_out[c]  = 7'h08 << cch_q[c][3:2];           // [RULE19]
		assign pre_pat_out[c]  = cch_q[c][1:0];                    // [RULE19]
		assign pre_flag_out[c] = cch_q[c][4];                      // [RULE20]
		// shave only meaningful when the transmitter is asynchronous
		assign shave_out[c]    = (cmh_q[c][3:0] == 4'h0) ? cch_q[c][3:0] : 4'h0; // [RULE21]
		assign msb_first_out[c] = msb_q[c];
		assign swapped_out[c]   = swp_q[c];
		assign rx_go_out[c] = !ccl_q[c][SCC_CCL_WAIT] || go_rx_q[c]; // [RULE17]
		assign tx_go_out[c] = !cch_q[c][SCC_CCH_WAIT] || go_tx_q[c]; // [RULE18]

		AST_RESET_ORDER: assert property (@(posedge mclk_in) disable iff (!nrst_in)
			rst |=> (!msb_q[c] && !swp_q[c] && op_q[c] == 2'b00))   // [RULE24]
			else $error("channel reset did not restore defaults");
		AST_MSB_SEL: assert property (@(posedge mclk_in) disable iff (!nrst_in)
			msb_s[c] |=> msb_q[c] until lsb_s[c] || rst)            // [RULE9]
			else $error("msb first not held");
		AST_SWAP_SEL: assert property (@(posedge mclk_in) disable iff (!nrst_in)
			(str_s[c] || swp_s[c]) |=> swp_q[c] == $past(swp_s[c])) // [RULE10]
			else $error("memory order select wrong");
		AST_RX_WAIT: assert property (@(posedge mclk_in) disable iff (!nrst_in)
			(ccl_q[c][SCC_CCL_WAIT] && !go_rx_q[c]) |-> !rx_go_out[c]) // [RULE17]
			else $error("receiver moved without trigger");
		AST_RX_TRIG: assert property (@(posedge mclk_in) disable iff (!nrst_in)
			(pulse_out[c][SCC_P_DMA_RX] && !rst) |=> rx_go_out[c])  // [RULE17]
			else $error("rx trigger ignored");
		AST_RCC_CLR: assert property (@(posedge mclk_in) disable iff (!nrst_in)
			(w_csh && wdata_in[SCC_CSH_RCC_CLR] && !rcc_push_in[c])
			|=> !rcc_valid_q[c] && !rcc_ovf_q[c])                   // [RULE14]
			else $error("count fifo not cleared");
		AST_MISS_SET: assert property (@(posedge mclk_in) disable iff (!nrst_in)
			clk_missed_in[c] |=> miss_q[c])                         // [RULE15]
			else $error("clocks missed event lost");
		AST_OPMODE: assert property (@(posedge mclk_in) disable iff (!nrst_in)
			(cah_wr[c] && !wdata_in[SCC_CAH_RST]) |=> op_mode_out[c] == $past(wdata_in[1:0])) // [RULE5]
			else $error("operating mode not taken");
		AST_RSV_CMD: assert property (@(posedge mclk_in) disable iff (!nrst_in)
			(cah_wr[c] && wdata_in[7:3] == 5'h18) |-> pulse_out[c] == '0 ##1 $stable(msb_q[c])) // [RULE23]
			else $error("reserved command acted");
	end

	// ==========================================================
	// read port: one cycle latency, unmapped offsets read zero
	logic [SCC_DW-1:0] rmux;
	logic [4:0] ia;
	logic [5:0] roff;
	always_comb begin
		ia   = iaddr_q[ch];
		roff = addr_in[SCC_CH_LSB-1:0];
		// offset 0 reads through the internal address pointer
		if (roff == SCC_OFF_CAL) begin
			unique case (ia)
				SCC_IA_MODE:  roff = SCC_OFF_CML;                  // [RULE2]
				SCC_IA_CSTAT: roff = SCC_OFF_CSL;                  // [RULE2]
				SCC_IA_CCTRL: roff = SCC_OFF_CCL;                  // [RULE2]
				default:      roff = SCC_OFF_CAL;
			endcase
		end
		unique case (roff)
			SCC_OFF_CML: rmux = cml_q[ch];
			SCC_OFF_CMH: rmux = cmh_q[ch];
			SCC_OFF_CSL: rmux = {on_loop_in[ch], loop_sending_in[ch],          // [RULE22]
				csl_q[ch][5:2], rx_ack_in[ch], tx_ack_in[ch]};
			SCC_OFF_CSH: rmux = {rcc_ovf_q[ch], rcc_valid_q[ch], 1'b0,         // [RULE14]
				pll_sync_in[ch], {2{miss_q[ch]}}, csh_q[ch][1:0]};             // [RULE15]
			SCC_OFF_CCL: rmux = ccl_q[ch];
			SCC_OFF_CCH: rmux = cch_q[ch];
			default:     rmux = '0;
		endcase
	end

	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in)
			rdata_out <= '0;
		else if (rd_in)
			rdata_out <= rmux;
		else
			rdata_out <= '0;
	end
endmodule
`default_nettype wire

/* bench/scc_host.sv */
// scc_host: host bus master for the serial channel control block
// assumes: slave never stalls, read data stands only in the cycle after the strobe
`timescale 1ns/10ps
`default_nettype none
module scc_host (
	input  wire logic       clk_in,    // block clock
	input  wire logic [7:0] rdata_in,  // read data
	output logic      [7:0] addr_out,  // byte address
	output logic      [7:0] wdata_out, // write data
	output logic            wr_out,    // write strobe
	output logic            rd_out     // read strobe
);
	initial begin
		addr_out = 8'h00;
		wdata_out = 8'h00;
		wr_out = 1'b0;
		rd_out = 1'b0;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		addr_out <= a;
		wdata_out <= d;
		wr_out <= 1'b1;
		@(posedge clk_in);
		wr_out <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_in);
		addr_out <= a;
		rd_out <= 1'b1;
		@(posedge clk_in);
		rd_out <= 1'b0;
		// let the registered answer land before taking it
		#1 d = rdata_in;
	endtask
	// lower byte and byte access always, address in d5..d1
	task automatic sel(input logic [1:0] ch, input logic [4:0] ia);
		wr({ch, 6'h00}, {2'b00, ia, 1'b0});
	endtask
endmodule
`default_nettype wire

/* bench/serial_channel_control_regs_test.sv */
// serial_channel_control_regs_test: self-checking bench for scc_ctrl
// assumes: scc_host drives the register port, status inputs driven here
`timescale 1ns/10ps
`default_nettype none
module serial_channel_control_regs_test;
	import scc_pkg::*;
	// ==========================================================
	// expected pulses, indexed by command code
	localparam logic [10:0] EXP [32] = '{11'h0, 11'h0, 11'h001, 11'h0, 11'h002, 11'h004,
		11'h008, 11'h00c, 11'h0, 11'h010, 11'h020, 11'h030, 11'h0, 11'h040, 11'h080,
		11'h0c0, 11'h0, 11'h100, 11'h200, 11'h300, 11'h0, 11'h0, 11'h0, 11'h0, 11'h0,
		11'h400, 11'h0, 11'h0, 11'h0, 11'h0, 11'h0, 11'h0};
	logic mclk = 1'b0;
	logic nrst = 1'b0;
	logic [7:0] addr, wdata, rdata, d;
	logic wr, rd;
	logic [3:0] txa = '0, rxa = '0, lps = '0, onl = '0, pll = '0, cmis = '0, push = '0;
	logic [3:0][1:0] opm, rsb, tsb, ppat;
	logic [3:0][3:0] rxm, txm, shv;
	logic [3:0][2:0] llen;
	logic [3:0][6:0] plen;
	logic [3:0] mrsv, pflg, msb, swp, rgo, tgo, crst, rall;
	logic [3:0][10:0] pls, pall, e;
	int fails = 0;
	int checks = 0;
	always #2 mclk = ~mclk;
	scc_ctrl dut_u (.mclk_in(mclk), .nrst_in(nrst), .addr_in(addr), .wdata_in(wdata),
		.wr_in(wr), .rd_in(rd), .rdata_out(rdata), .tx_ack_in(txa), .rx_ack_in(rxa),
		.loop_sending_in(lps), .on_loop_in(onl), .pll_sync_in(pll), .clk_missed_in(cmis),
		.rcc_push_in(push), .rcc_pop_in(4'h0), .op_mode_out(opm), .rx_mode_out(rxm),
		.tx_mode_out(txm), .mode_rsv_out(mrsv), .last_len_out(llen), .rx_sblk_out(rsb),
		.tx_sblk_out(tsb), .pre_len_out(plen), .pre_pat_out(ppat), .pre_flag_out(pflg),
		.shave_out(shv), .msb_first_out(msb), .swapped_out(swp), .rx_go_out(rgo),
		.tx_go_out(tgo), .pulse_out(pls), .chan_rst_out(crst));
	scc_host host_u (.clk_in(mclk), .rdata_in(rdata), .addr_out(addr), .wdata_out(wdata),
		.wr_out(wr), .rd_out(rd));
	// ==========================================================
	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// pulses are sampled mid-cycle of the strobe, registers after it
	task automatic w(input logic [7:0] a, input logic [7:0] v);
		fork
			host_u.wr(a, v);
			begin
				@(posedge mclk);
				@(negedge mclk);
				pall = pls;
				rall = crst;
			end
		join
		@(negedge mclk);
	endtask
	task automatic r(input logic [7:0] a, input logic [7:0] v);
		host_u.rd(a, d);
		chk(d, v);
	endtask
	task automatic conclude();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		#20000;
		fails++;
		conclude();
	end
	// ==========================================================
	initial begin
		repeat (5) @(posedge mclk);
		nrst <= 1'b1;
		@(negedge mclk);
		chk({msb, swp, opm}, '0);
		for (int i = 0; i < 32; i++) begin
			w({i[1:0], SCC_OFF_CAH}, {i[4:0], 3'b000});
			e = '0;
			e[i[1:0]] = EXP[i];
			chk(pall, e);
		end
		chk({msb, swp}, 8'h28);
		for (int m = 0; m < 4; m++) begin
			w(8'h82, m[7:0]);
			chk(opm[2], m[1:0]);
		end
		w(8'h44, 8'h5a);
		chk({rxm[1], mrsv[1]}, 5'h15);
		w(8'h44, 8'h09);
		r(8'h44, 8'h09);
		w(8'h46, 8'h0c);
		chk({txm[1], mrsv[1]}, 5'h18);
		w(8'h46, 8'h01);
		chk(mrsv[1], 1'b1);
		w(8'h46, 8'h00);
		w(8'h4c, 8'h60);
		chk({rsb[1], rgo[1]}, 3'h2);
		w(8'h42, 8'h28);
		chk(rgo[1], 1'b1);
		host_u.sel(2'h1, SCC_IA_CCTRL);
		r(8'h40, 8'h60);
		txa <= 4'h2;
		lps <= 4'h2;
		onl <= 4'h2;
		pll <= 4'h2;
		w(8'h48, 8'h1c);
		chk(llen[1], 3'h7);
		host_u.sel(2'h1, SCC_IA_CSTAT);
		r(8'h40, 8'hdd);
		w(8'h4e, 8'h3d);
		chk({plen[1], ppat[1], pflg[1], shv[1], tgo[1]}, 15'h407a);
		w(8'h42, 8'h30);
		chk(tgo[1], 1'b1);
		for (int k = 0; k < 4; k++) begin
			w(8'h4e, {4'h8, k[1:0], 2'b00});
			chk({tsb[1], plen[1]}, {2'h2, 7'(8 << k)});
		end
		for (int k = 0; k < 10; k++) begin
			@(posedge mclk);
			push <= (k == 0 || k == 9) ? 4'h0 : 4'h2;
			cmis <= (k == 0) ? 4'h2 : 4'h0;
			if (k == 1)
				r(8'h4a, 8'h5c);
			if (k == 2)
				w(8'h4a, 8'h24);
			if (k == 3)
				r(8'h4a, 8'h50);
		end
		repeat (6) begin
			@(posedge mclk);
			push <= 4'h2;
			@(posedge mclk);
			push <= 4'h0;
		end
		r(8'h4a, 8'hd0);
		w(8'h42, 8'h04);
		chk({rall, pall}, 48'h2 << 44);
		chk({rxm[1], msb[1], tgo[1], plen[1]}, {4'h0, 1'b0, 1'b1, 7'h08});
		r(8'h4a, 8'h10);
		w(8'h50, 8'hff);
		r(8'h50, 8'h00);
		r(8'h02, 8'h00);
		conclude();
	end
endmodule
`default_nettype wire
